// ---- hdl/awh_pkg.sv ----
// Package for the alarm weekday/hour value register bank.
// Assumes a single APB clock domain; no other package is needed.
package awh_pkg;

   // ****************************************************************
   // Register map (byte addresses on the APB word grid)
   // ****************************************************************
   localparam logic [7:0]  ADDR_MONTH_DAY   = 8'h00;  // Alarm month/day value
   localparam logic [7:0]  ADDR_ALARM_WEEKDAY_DIGIT_HOUR   = 8'h04;  // Alarm weekday/hour value
   localparam logic [7:0]  ADDR_ALARM_CTRL  = 8'h08;  // Unlock, arm, mask
   localparam logic [7:0]  ADDR_CLOCK_NOW   = 8'h0C;  // Current clock digits
   localparam logic [7:0]  ADDR_STATUS      = 8'h10;  // Alarm status

   // ****************************************************************
   // Field layout
   // ****************************************************************
   localparam int          ALARM_WEEKDAY_DIGIT_LSB         = 8;      // Weekday digit 10:8
   localparam int          HTEN_LSB         = 4;      // Hour tens 5:4
   localparam int          HONE_LSB         = 0;      // Hour ones 3:0
   localparam logic [15:0] ALARM_WEEKDAY_DIGIT_HOUR_MASK   = 16'h073F;  // Implemented bits
   localparam logic [15:0] MONTH_DAY_MASK   = 16'h1F3F;  // Implemented bits
   localparam int          CTRL_UNLOCK_BIT  = 0;      // clock_write_unlock
   localparam int          CTRL_ARM_BIT     = 1;      // alarm_arm
   localparam int          CTRL_MASK_LSB    = 4;      // alarm_match_mask 7:4
   localparam int          STAT_FIRED_BIT   = 0;      // Sticky alarm-fired flag

   // ****************************************************************
   // Digit limits and match-mask codes
   // ****************************************************************
   localparam logic [2:0]  ALARM_WEEKDAY_DIGIT_MAX         = 3'h6;
   localparam logic [1:0]  HTEN_MAX         = 2'h2;
   localparam logic [3:0]  HONE_MAX         = 4'h9;
   localparam logic [3:0]  MASK_DAY         = 4'h6;   // Match hours
   localparam logic [3:0]  MASK_WEEK        = 4'h7;   // Match weekday and hours
   localparam logic [3:0]  MASK_MONTH       = 4'h8;   // Match day and hours
   localparam logic [3:0]  MASK_YEAR        = 4'h9;   // Match month, day and hours

endpackage : awh_pkg

// ---- hdl/awh_match.sv ----
// Alarm digit comparator: decides whether the running clock digits match
// the stored alarm digits under the selected match mask.
// Assumes clock digits arrive already synchronised to pclk.
module awh_match
   import awh_pkg::*;
(
   input  wire logic [3:0]  match_mask,   // Selects which digits must agree
   input  wire logic [15:0] alarm_wdhr,   // Stored weekday/hour value
   input  wire logic [15:0] alarm_mday,   // Stored month/day value
   input  wire logic [15:0] clock_wdhr,   // Running weekday/hour digits
   input  wire logic [15:0] clock_mday,   // Running month/day digits
   output logic             hit           // Combinational match result
);

   // ****************************************************************
   // Digit comparison
   // ****************************************************************
   logic hour_eq;  // Hour digits agree
   logic alarm_weekday_digit_eq;  // Weekday digit agrees
   logic day_eq;   // Day digits agree
   logic mon_eq;   // Month digits agree

   // Compare each field under its implemented-bit mask
   always_comb begin
      hour_eq = (alarm_wdhr[5:0] == clock_wdhr[5:0]);
      alarm_weekday_digit_eq = (alarm_wdhr[10:8] == clock_wdhr[10:8]);
      day_eq  = (alarm_mday[5:0] == clock_mday[5:0]);
      mon_eq  = (alarm_mday[12:8] == clock_mday[12:8]);
      // Only the modes whose digits this bank holds are decided here
      case (match_mask)
         MASK_DAY:   hit = hour_eq;
         MASK_WEEK:  hit = hour_eq && alarm_weekday_digit_eq;
         MASK_MONTH: hit = hour_eq && day_eq;
         MASK_YEAR:  hit = hour_eq && day_eq && mon_eq;
         default:    hit = 1'b0;
      endcase
   end

endmodule // awh_match

// ---- hdl/awh_regs.sv ----
// Alarm weekday/hour and month/day value registers with an APB slave.
// Assumes clock digits come from another domain and are synchronised here;
// the arm bit is cleared by hardware when the alarm fires.

module awh_regs
   import awh_pkg::*;
(
   input  wire logic        pclk,            // APB clock, 40 MHz
   input  wire logic        presetn,         // Asynchronous reset, active low
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB access phase
   input  wire logic        pwrite,          // APB direction, high for write
   input  wire logic [7:0]  paddr,           // APB byte address
   input  wire logic [31:0] pwdata,          // APB write data
   input  wire logic [3:0]  pstrb,           // APB byte strobes
   output logic [31:0]      prdata,          // APB read data
   output logic             pready,          // APB ready
   output logic             pslverr,         // APB error
   input  wire logic [15:0] clock_wdhr_in,   // Running weekday/hour, async
   input  wire logic [15:0] clock_mday_in,   // Running month/day, async
   output logic             alarm_event      // One-cycle alarm pulse
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [15:0] wdhr;         // alarm_weekday_hour_reg
      logic [15:0] mday;         // alarm_month_day_value
      logic        unlock;       // clock_write_unlock
      logic        arm;          // alarm_arm
      logic [3:0]  mask;         // alarm_match_mask
      logic        fired;        // Sticky alarm-fired flag
      logic        hit_d;        // Last match, for edge detection
      logic        event_p;      // Alarm pulse
      logic [31:0] rdata;        // Registered read data
      logic        err;          // Registered error answer
      logic        done;         // Access answered this cycle
      logic [15:0] cw_s1;        // Sync stage 1, weekday/hour
      logic [15:0] cw_s2;        // Sync stage 2, weekday/hour
      logic [15:0] cm_s1;        // Sync stage 1, month/day
      logic [15:0] cm_s2;        // Sync stage 2, month/day
      logic [15:0] cw_s3;        // Settle stage, weekday/hour
      logic [15:0] cm_s3;        // Settle stage, month/day
      logic [15:0] cw_ok;        // Settled weekday/hour word
      logic [15:0] cm_ok;        // Settled month/day word
   } awh_state_s;

   awh_state_s st_reg;   // Current state
   awh_state_s st_next;  // Next state
   logic       hit;      // Comparator result

   // ****************************************************************
   // Comparator
   // ****************************************************************
   awh_match u_match (
      .match_mask (st_reg.mask),
      .alarm_wdhr (st_reg.wdhr),
      .alarm_mday (st_reg.mday),
      .clock_wdhr (st_reg.cw_ok),
      .clock_mday (st_reg.cm_ok),
      .hit        (hit)
   );

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   logic        acc;      // Access phase, answered in its second cycle
   logic        wr;       // Write takes effect
   logic [15:0] wd_lo;    // Low half of write data after strobes
   logic        fire;     // Alarm fires this cycle

   // One wait state keeps read data registered and the answer simple
   always_comb begin
      st_next = st_reg;
      acc     = psel && penable && !st_reg.done;
      wr      = acc && pwrite;
      wd_lo   = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
      // Synchronisers: stage 1 is read only by stage 2
      st_next.cw_s1 = clock_wdhr_in;
      st_next.cw_s2 = st_reg.cw_s1;
      st_next.cm_s1 = clock_mday_in;
      st_next.cm_s2 = st_reg.cm_s1;
      // Third stage only feeds the settle test; stage 1 stays private to stage 2
      st_next.cw_s3 = st_reg.cw_s2;
      st_next.cm_s3 = st_reg.cm_s2;
      // A multi-bit word may be caught mid-change, so only a word seen twice in a row
      // is passed on; this assumes the running clock changes far slower than pclk
      if (st_reg.cw_s2 == st_reg.cw_s3) begin
         st_next.cw_ok = st_reg.cw_s2;
      end
      if (st_reg.cm_s2 == st_reg.cm_s3) begin
         st_next.cm_ok = st_reg.cm_s2;
      end
      st_next.done  = acc;
      st_next.err   = 1'b0;
      st_next.rdata = 32'h0000_0000;
      // Rising match edge fires once while armed, then disarms
      fire            = st_reg.arm && hit && !st_reg.hit_d;
      st_next.hit_d   = hit;
      st_next.event_p = fire;
      if (fire) begin
         st_next.arm   = 1'b0;
         st_next.fired = 1'b1;
      end
      if (wr) begin
         case (paddr)
            ADDR_ALARM_WEEKDAY_DIGIT_HOUR: begin
               // Locked writes are dropped silently
               if (st_reg.unlock) begin
                  st_next.wdhr = wd_lo & ALARM_WEEKDAY_DIGIT_HOUR_MASK;
               end
            end
            ADDR_MONTH_DAY:  st_next.mday = wd_lo & MONTH_DAY_MASK;
            ADDR_ALARM_CTRL: begin
               st_next.unlock = wd_lo[CTRL_UNLOCK_BIT];
               // A fire in the same cycle wins over software re-arming
               st_next.arm    = wd_lo[CTRL_ARM_BIT] && !fire;
               st_next.mask   = wd_lo[CTRL_MASK_LSB +: 4];
            end
            ADDR_STATUS: begin
               // Write one to clear; a new fire wins
               if (wd_lo[STAT_FIRED_BIT] && !fire) begin
                  st_next.fired = 1'b0;
               end
            end
            ADDR_CLOCK_NOW: st_next.err = 1'b1;   // Read-only
            default:        st_next.err = 1'b1;   // Unmapped
         endcase
      end else if (acc) begin
         case (paddr)
            ADDR_ALARM_WEEKDAY_DIGIT_HOUR:  st_next.rdata = {16'h0000, st_reg.wdhr & ALARM_WEEKDAY_DIGIT_HOUR_MASK};
            ADDR_MONTH_DAY:  st_next.rdata = {16'h0000, st_reg.mday & MONTH_DAY_MASK};
            ADDR_ALARM_CTRL: st_next.rdata = {24'h00_0000, st_reg.mask, 2'b00, st_reg.arm, st_reg.unlock};
            ADDR_CLOCK_NOW:  st_next.rdata = {st_reg.cm_ok, st_reg.cw_ok};
            ADDR_STATUS:     st_next.rdata = {31'h0000_0000, st_reg.fired};
            default:         st_next.err   = 1'b1;
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Alarm values need no defined start in use; zero here gives a clean start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign pready      = st_reg.done;
   assign prdata      = st_reg.rdata;
   assign pslverr     = st_reg.done && st_reg.err;
   assign alarm_event = st_reg.event_p;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_locked_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == ADDR_ALARM_WEEKDAY_DIGIT_HOUR && !st_reg.unlock)
      |=> $stable(st_reg.wdhr))
      else $error("weekday/hour changed while locked");
   a_unlocked_write_taken: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == ADDR_ALARM_WEEKDAY_DIGIT_HOUR && st_reg.unlock && pstrb == 4'hF)
      |=> st_reg.wdhr == ($past(pwdata[15:0]) & ALARM_WEEKDAY_DIGIT_HOUR_MASK))
      else $error("unlocked weekday/hour write lost");
   a_wdhr_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && !pready && paddr == ADDR_ALARM_WEEKDAY_DIGIT_HOUR)
      |=> pready && prdata[15:11] == 5'h00 && prdata[7:6] == 2'h0)
      else $error("unimplemented bits read nonzero");
   a_alarm_weekday_digit_field: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && !pready && paddr == ADDR_ALARM_WEEKDAY_DIGIT_HOUR)
      |=> prdata[10:8] == $past(st_reg.wdhr[10:8]))
      else $error("weekday field misplaced");
   a_hour_field: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && !pready && paddr == ADDR_ALARM_WEEKDAY_DIGIT_HOUR)
      |=> prdata[5:0] == $past(st_reg.wdhr[5:0]))
      else $error("hour fields misplaced");
   a_dead_bits_store: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.wdhr[15:11] == 5'h00 && st_reg.wdhr[7:6] == 2'h0)
      else $error("stored value holds unimplemented bits");
   // Each digit lands in its own field when its byte lane is strobed
   a_alarm_weekday_digit_store: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == ADDR_ALARM_WEEKDAY_DIGIT_HOUR && st_reg.unlock && pstrb[1])
      |=> st_reg.wdhr[ALARM_WEEKDAY_DIGIT_LSB +: 3] == $past(pwdata[ALARM_WEEKDAY_DIGIT_LSB +: 3]))
      else $error("weekday digit not stored");
   a_hour_tens_store: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == ADDR_ALARM_WEEKDAY_DIGIT_HOUR && st_reg.unlock && pstrb[0])
      |=> st_reg.wdhr[HTEN_LSB +: 2] == $past(pwdata[HTEN_LSB +: 2]))
      else $error("hour tens digit not stored");
   a_hour_ones_store: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == ADDR_ALARM_WEEKDAY_DIGIT_HOUR && st_reg.unlock && pstrb[0])
      |=> st_reg.wdhr[HONE_LSB +: 4] == $past(pwdata[HONE_LSB +: 4]))
      else $error("hour ones digit not stored");
   // An unstrobed lane is written as zero, not kept
   a_lane_cleared: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !pready && paddr == ADDR_ALARM_WEEKDAY_DIGIT_HOUR && st_reg.unlock && !pstrb[0])
      |=> st_reg.wdhr[HONE_LSB +: 4] == 4'h0)
      else $error("unstrobed hour lane kept old value");
   // The fired flag only falls on a clearing write
   a_fired_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg.fired && !(psel && penable && pwrite && !pready && paddr == ADDR_STATUS && pstrb[0]
                         && pwdata[STAT_FIRED_BIT]))
      |=> st_reg.fired)
      else $error("fired flag dropped without a clear");
   a_alarm_fires: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg.arm && hit && !st_reg.hit_d) |=> alarm_event ##1 !alarm_event)
      else $error("alarm pulse missing");
   a_alarm_disarms: assert property (@(posedge pclk) disable iff (!presetn)
      alarm_event |-> !st_reg.arm && st_reg.fired)
      else $error("alarm left armed after firing");

endmodule // awh_regs

// ---- bench/alarm_weekday_hour_value_regs_tb.sv ----
// Self-checking bench for the alarm weekday/hour value register bank.
// Assumes awh_pkg and awh_regs are compiled first; one 40 MHz clock.
module alarm_weekday_hour_value_regs_tb
   import awh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Signals, model state and counters
   // ****************************************************************
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, alarm_event;
   logic [7:0]  paddr;          // Byte address
   logic [31:0] pwdata, prdata; // Bus data
   logic [3:0]  pstrb;          // Byte strobes
   logic [15:0] clk_wdhr, clk_mday; // Running clock digits we pretend to be
   logic [15:0] m_wdhr, m_mday; // Model copies of the two value registers
   logic        m_unlock;       // Model copy of clock_write_unlock
   logic [31:0] seed;           // Xorshift state
   int          err_count, comparisons, cyc;

   awh_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clock_wdhr_in(clk_wdhr), .clock_mday_in(clk_mday),
      .alarm_event(alarm_event));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Clock, 25 ns period
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Hang guard: the whole run needs well under two thousand cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         give_verdict();
      end
   end

   // Xorshift source, fixed start so every run is the same
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Single comparison point
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // No fixed wait is assumed; only the hang guard ends a silent slave
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Write and update the model; unstrobed lanes land as zero
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] rd;
      logic        er;
      logic [15:0] v;
      v = d[15:0] & {{8{s[1]}}, {8{s[0]}}};
      apb(1'b1, a, d, s, rd, er);
      check("write error flag", {31'h0, er}, 32'h0);
      if (a == ADDR_ALARM_WEEKDAY_DIGIT_HOUR && m_unlock) m_wdhr = v & ALARM_WEEKDAY_DIGIT_HOUR_MASK;
      if (a == ADDR_MONTH_DAY) m_mday = v & MONTH_DAY_MASK;
      if (a == ADDR_ALARM_CTRL) m_unlock = v[CTRL_UNLOCK_BIT];
   endtask

   // Read and compare against an expected word
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic        er;
      apb(1'b0, a, 32'h0, 4'h0, d, er);
      check(what, d, exp);
      check("read error flag", {31'h0, er}, 32'h0);
   endtask

   task automatic give_verdict();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [31:0] d;
      logic        er;
      logic [3:0]  md [5];
      logic [15:0] cw, cm;
      logic        hit;
      md = '{4'h3, MASK_DAY, MASK_WEEK, MASK_MONTH, MASK_YEAR};
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, clk_wdhr, clk_mday} = '0;
      {m_wdhr, m_mday, m_unlock} = '0;
      seed = 32'h0000D24B;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_ALARM_WEEKDAY_DIGIT_HOUR, 32'h0, "weekday/hour after reset");
      rd(ADDR_ALARM_CTRL, 32'h0, "ctrl after reset");
      // Locked write must leave the register alone
      wr(ADDR_ALARM_WEEKDAY_DIGIT_HOUR, 32'h0000_0623, 4'hF);
      rd(ADDR_ALARM_WEEKDAY_DIGIT_HOUR, {16'h0, m_wdhr}, "locked write");
      $display("test locked write done");
      // Unlocked writes with random data and strobes; dead bits read zero
      wr(ADDR_ALARM_CTRL, 32'h1, 4'hF);
      for (int i = 0; i < 12; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : rnd();
         wr(ADDR_ALARM_WEEKDAY_DIGIT_HOUR, d, (i == 0) ? 4'hF : d[19:16]);
         rd(ADDR_ALARM_WEEKDAY_DIGIT_HOUR, {16'h0, m_wdhr}, "weekday/hour field");
      end
      wr(ADDR_ALARM_CTRL, 32'h0, 4'hF);
      wr(ADDR_ALARM_WEEKDAY_DIGIT_HOUR, {16'h0, ~m_wdhr}, 4'hF);
      rd(ADDR_ALARM_WEEKDAY_DIGIT_HOUR, {16'h0, m_wdhr}, "relocked write");
      apb(1'b0, 8'hFC, 32'h0, 4'h0, d, er);
      check("unmapped error flag", {31'h0, er}, 32'h1);
      $display("test field access done");
      // Each mask mode: only the selected digits have to agree
      foreach (md[k]) begin
         hit = (md[k] != 4'h3);
         cw = (md[k] == MASK_DAY) ? 16'h0513 : 16'h0213;
         cm = (md[k] < MASK_MONTH) ? 16'h0000 : ((md[k] == MASK_MONTH) ? 16'h0925 : 16'h1125);
         clk_wdhr <= 16'h0000;
         clk_mday <= 16'h0000;
         wr(ADDR_ALARM_CTRL, 32'h1, 4'hF); // Disarmed while values change
         wr(ADDR_ALARM_WEEKDAY_DIGIT_HOUR, 32'h0000_0213, 4'hF);
         wr(ADDR_MONTH_DAY, 32'h0000_1125, 4'hF);
         rd(ADDR_MONTH_DAY, {16'h0, m_mday}, "month/day value");
         wr(ADDR_ALARM_CTRL, {24'h0, md[k], 4'h3}, 4'hF);
         @(posedge pclk);
         clk_wdhr <= cw;
         clk_mday <= cm;
         er = 1'b0;
         repeat (12) begin
            @(posedge pclk);
            er = er | (alarm_event === 1'b1);
         end
         check("alarm pulse", {31'h0, er}, {31'h0, hit});
         rd(ADDR_ALARM_CTRL, {24'h0, md[k], 2'b0, ~hit, 1'b1}, "arm after match");
         rd(ADDR_STATUS, {31'h0, hit}, "fired flag");
         rd(ADDR_CLOCK_NOW, {cm, cw}, "clock digits");
         wr(ADDR_STATUS, 32'h1, 4'hF);
         rd(ADDR_STATUS, 32'h0, "fired cleared");
         $display("test mask mode %h done", md[k]);
      end
      give_verdict();
   end

endmodule // alarm_weekday_hour_value_regs_tb
